// [rtl/asbrg_pkg.sv]
package asbrg_pkg;
    localparam int unsigned ASBRG_CH_N = 2;
    // Prescale ratios
    localparam logic [4:0] ASBRG_PRE_DIV_LO = 5'h0a;
    localparam logic [4:0] ASBRG_PRE_DIV_HI = 5'h1e;
    // Sampling ratios
    localparam logic [6:0] ASBRG_SMP_DIV_LO = 7'h10;
    localparam logic [6:0] ASBRG_SMP_DIV_HI = 7'h40;
    // External clock divide
    localparam logic [4:0] ASBRG_EXT_DIV = 5'h10;
    localparam logic [2:0] ASBRG_SPEED_EXT = 3'h7;
    localparam logic [2:0] ASBRG_SPEED_RST = 3'h0;
    localparam logic ASBRG_PRESCALE_RST = 1'b0;
    localparam logic ASBRG_SMP_RATIO_RST = 1'b0;
    localparam int unsigned ASBRG_CNT_W = 17;
    localparam int unsigned ASBRG_FCTR = 3;

    typedef enum logic [1:0] {
        ASBRG_SRC_INT = 2'b01,
        ASBRG_SRC_EXT = 2'b10
    } asbrg_src_e;
endpackage : asbrg_pkg

// [rtl/asbrg_cfg_if.sv]
`timescale 1ns/100ps
interface asbrg_cfg_if;
    import asbrg_pkg::*;
    logic prescale_select;
    logic sampling_ratio_select;
    logic [2:0] speed_select;
    logic ext_clk;
    logic baud_tick;
    logic bit_tick;
    modport ctl (output prescale_select, output sampling_ratio_select, output speed_select,
                 output ext_clk, input baud_tick, input bit_tick);
    modport gen (input prescale_select, input sampling_ratio_select, input speed_select,
                 input ext_clk, output baud_tick, output bit_tick);
endinterface : asbrg_cfg_if

// [rtl/asbrg_chan.sv]
`timescale 1ns/100ps
module asbrg_chan
    import asbrg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    asbrg_cfg_if.gen cfg
);
    typedef struct packed {
        logic [ASBRG_CNT_W-1:0] cnt;
        logic [3:0] ext_cnt;
        logic ext_q;
        logic baud;
        logic bit_t;
        logic [5:0] smp_cnt;
    } asbrg_chan_s;

    asbrg_chan_s st_reg;
    asbrg_chan_s st_next;
    logic [ASBRG_CNT_W-1:0] div_top;
    logic [5:0] smp_top;
    logic ext_rise;

    // =====================================
    // Divider
    always_comb
    begin
        // Top of the internal divider: prescale x 2^speed minus 1, the sampling stage follows
        div_top = (ASBRG_CNT_W)'(cfg.prescale_select ? ASBRG_PRE_DIV_HI : ASBRG_PRE_DIV_LO)
                  << cfg.speed_select;
        div_top = div_top - 17'h00001;
        smp_top = cfg.sampling_ratio_select ? 6'(ASBRG_SMP_DIV_HI - 7'h01)
                                            : 6'(ASBRG_SMP_DIV_LO - 7'h01);
        ext_rise = cfg.ext_clk & ~st_reg.ext_q;
        st_next = st_reg;
        st_next.baud = 1'b0;
        st_next.bit_t = 1'b0;
        st_next.ext_q = cfg.ext_clk;
        if (cfg.speed_select == ASBRG_SPEED_EXT)
        begin
            // External source: one bit time per 16 edges, sampling stage bypassed
            st_next.cnt = '0;
            st_next.smp_cnt = '0;
            if (ext_rise)
            begin
                st_next.baud = 1'b1;
                st_next.ext_cnt = st_reg.ext_cnt + 4'h1;
                if (st_reg.ext_cnt == 4'(ASBRG_EXT_DIV - 5'h01))
                begin
                    st_next.bit_t = 1'b1;
                end
            end
        end
        else
        begin
            st_next.ext_cnt = '0;
            if (st_reg.cnt >= div_top)
            begin
                st_next.cnt = '0;
                st_next.baud = 1'b1;
                if (st_reg.smp_cnt >= smp_top)
                begin
                    st_next.smp_cnt = '0;
                    st_next.bit_t = 1'b1;
                end
                else
                begin
                    st_next.smp_cnt = st_reg.smp_cnt + 6'h01;
                end
            end
            else
            begin
                st_next.cnt = st_reg.cnt + 17'h00001;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign cfg.baud_tick = st_reg.baud;
    assign cfg.bit_tick = st_reg.bit_t;
endmodule : asbrg_chan

// [rtl/asbrg_top.sv]
`timescale 1ns/100ps
// Summary of operation
// - Prescale divides system clock by 10 when select is 0, 30 when 1.
// - Sampling division is 16 when ratio select is 0, 64 when 1.
// - Speed codes 000-110 multiply divisor by 1 to 64; 111 picks external clock.
// - External clock source gives a bit rate of external clock divided by 16.
// - Reset clears prescale select; clear-to-send status follows its pin.
module asbrg_top
    import asbrg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [ASBRG_CH_N-1:0] cfg_we_i,
    input wire logic [ASBRG_CH_N-1:0] prescale_select_i,
    input wire logic [ASBRG_CH_N-1:0] sampling_ratio_select_i,
    input wire logic [3*ASBRG_CH_N-1:0] speed_select_i,
    input wire logic [ASBRG_CH_N-1:0] ext_clk_i,
    input wire logic [ASBRG_CH_N-1:0] clear_to_send_n_i,
    output logic [ASBRG_CH_N-1:0] prescale_select_o,
    output logic [ASBRG_CH_N-1:0] sampling_ratio_select_o,
    output logic [3*ASBRG_CH_N-1:0] speed_select_o,
    output logic [ASBRG_CH_N-1:0] clear_to_send_n_o,
    output logic [ASBRG_CH_N-1:0] ext_src_o,
    output logic [ASBRG_CH_N-1:0] sample_tick_o,
    output logic [ASBRG_CH_N-1:0] bit_tick_o
);
    typedef struct packed {
        logic [ASBRG_CH_N-1:0] pre_sel;
        logic [ASBRG_CH_N-1:0] smp_sel;
        logic [3*ASBRG_CH_N-1:0] ss;
        logic [ASBRG_CH_N-1:0] cts;
    } asbrg_top_s;

    asbrg_top_s st_reg;
    asbrg_top_s st_next;

    // =====================================
    // Configuration fields
    always_comb
    begin
        st_next = st_reg;
        // Status tracks the pin, reset loads all ones
        st_next.cts = clear_to_send_n_i;
        for (int i = 0; i < ASBRG_CH_N; i++)
        begin
            if (cfg_we_i[i])
            begin
                st_next.pre_sel[i] = prescale_select_i[i];
                st_next.smp_sel[i] = sampling_ratio_select_i[i];
                st_next.ss[3*i +: 3] = speed_select_i[3*i +: 3];
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_reg.pre_sel <= {ASBRG_CH_N{ASBRG_PRESCALE_RST}};
            st_reg.smp_sel <= {ASBRG_CH_N{ASBRG_SMP_RATIO_RST}};
            st_reg.ss <= {ASBRG_CH_N{ASBRG_SPEED_RST}};
            st_reg.cts <= '1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign prescale_select_o = st_reg.pre_sel;
    assign sampling_ratio_select_o = st_reg.smp_sel;
    assign speed_select_o = st_reg.ss;
    assign clear_to_send_n_o = st_reg.cts;

    // =====================================
    // Channel generators
    for (genvar g = 0; g < ASBRG_CH_N; g++)
    begin : g_ch
        asbrg_cfg_if cfg_if ();
        assign cfg_if.prescale_select = st_reg.pre_sel[g];
        assign cfg_if.sampling_ratio_select = st_reg.smp_sel[g];
        assign cfg_if.speed_select = st_reg.ss[3*g +: 3];
        // Caller keeps this below clock/40, edges are not filtered
        assign cfg_if.ext_clk = ext_clk_i[g];
        assign ext_src_o[g] = (st_reg.ss[3*g +: 3] == ASBRG_SPEED_EXT);
        assign sample_tick_o[g] = cfg_if.baud_tick;
        assign bit_tick_o[g] = cfg_if.bit_tick;
        asbrg_chan u_chan (
            .clk_sys_i(clk_sys_i),
            .rst_i(rst_i),
            .cfg(cfg_if.gen)
        );
    end
endmodule : asbrg_top

// [sim/asbrg_top_checker.sv]
`timescale 1ns/100ps
module asbrg_top_checker
    import asbrg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [ASBRG_CH_N-1:0] cfg_we_i,
    input wire logic [ASBRG_CH_N-1:0] clear_to_send_n_i,
    input wire logic [ASBRG_CH_N-1:0] prescale_select_o,
    input wire logic [ASBRG_CH_N-1:0] sampling_ratio_select_o,
    input wire logic [3*ASBRG_CH_N-1:0] speed_select_o,
    input wire logic [ASBRG_CH_N-1:0] clear_to_send_n_o,
    input wire logic [ASBRG_CH_N-1:0] ext_src_o,
    input wire logic [ASBRG_CH_N-1:0] sample_tick_o,
    input wire logic [ASBRG_CH_N-1:0] bit_tick_o
);
    // Writes drop attempts: the divider is not restarted
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i || (|cfg_we_i));
    property p_cts;
        !$past(rst_i) |-> clear_to_send_n_o == $past(clear_to_send_n_i);
    endproperty
    a_cts: assert property (p_cts) else $error("cts copy wrong");
    property p_ps_rst;
        $fell(rst_i) |-> prescale_select_o == '0;
    endproperty
    a_ps_rst: assert property (p_ps_rst) else $error("prescale not cleared");
    property p_ext;
        ext_src_o == {speed_select_o[5:3] == 3'h7, speed_select_o[2:0] == 3'h7};
    endproperty
    a_ext: assert property (p_ext) else $error("ext source decode wrong");
    property p_smp10;
        sample_tick_o[0] && !prescale_select_o[0] && speed_select_o[2:0] == 3'h0
            |=> !sample_tick_o[0] [*8] ##1 !sample_tick_o[0] ##1 sample_tick_o[0];
    endproperty
    a_smp10: assert property (p_smp10) else $error("sample period not 10");
    property p_smp30;
        sample_tick_o[0] && prescale_select_o[0] && speed_select_o[2:0] == 3'h0 |-> ##30 sample_tick_o[0];
    endproperty
    a_smp30: assert property (p_smp30) else $error("sample period not 30");
    property p_bit160;
        bit_tick_o[1] && !prescale_select_o[1] && !sampling_ratio_select_o[1] && speed_select_o[5:3] == 3'h0
            |-> ##160 bit_tick_o[1];
    endproperty
    a_bit160: assert property (p_bit160) else $error("bit period not 160");
endmodule : asbrg_top_checker

bind asbrg_top asbrg_top_checker chk_u (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .cfg_we_i(cfg_we_i),
    .clear_to_send_n_i(clear_to_send_n_i),
    .prescale_select_o(prescale_select_o),
    .sampling_ratio_select_o(sampling_ratio_select_o),
    .speed_select_o(speed_select_o),
    .clear_to_send_n_o(clear_to_send_n_o),
    .ext_src_o(ext_src_o),
    .sample_tick_o(sample_tick_o),
    .bit_tick_o(bit_tick_o)
);

// [sim/asbrg_top_tb_top.sv]
`timescale 1ns/100ps
module asbrg_top_tb_top;
    import asbrg_pkg::*;
    logic clk_sys_i, rst_i;
    logic [1:0] cfg_we_i, prescale_select_i, sampling_ratio_select_i, ext_clk_i, clear_to_send_n_i;
    logic [5:0] speed_select_i, speed_select_o, ext_cnt;
    logic [1:0] prescale_select_o, sampling_ratio_select_o, clear_to_send_n_o, ext_src_o, sample_tick_o, bit_tick_o;
    int miscompares, checks;
    asbrg_top dut_u (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .cfg_we_i(cfg_we_i),
        .prescale_select_i(prescale_select_i),
        .sampling_ratio_select_i(sampling_ratio_select_i),
        .speed_select_i(speed_select_i),
        .ext_clk_i(ext_clk_i),
        .clear_to_send_n_i(clear_to_send_n_i),
        .prescale_select_o(prescale_select_o),
        .sampling_ratio_select_o(sampling_ratio_select_o),
        .speed_select_o(speed_select_o),
        .clear_to_send_n_o(clear_to_send_n_o),
        .ext_src_o(ext_src_o),
        .sample_tick_o(sample_tick_o),
        .bit_tick_o(bit_tick_o)
    );
    initial
    begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // Slow enough to stay under clk/40
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            ext_cnt <= 6'h00;
            ext_clk_i <= 2'h0;
        end
        else
        begin
            ext_cnt <= ext_cnt + 6'h01;
            ext_clk_i <= {2{ext_cnt[5]}};
        end
    end
    // ==========
    // Tasks
    task automatic cmp(input logic [15:0] a, input logic [15:0] e);
        checks++;
        if (a !== e)
        begin
            miscompares++;
            $display("mismatch t=%0t got %h exp %h", $time, a, e);
        end
    endtask : cmp
    task automatic wr(input int c, input logic p, input logic d, input logic [2:0] s);
        @(posedge clk_sys_i);
        cfg_we_i[c] <= 1'b1;
        prescale_select_i[c] <= p;
        sampling_ratio_select_i[c] <= d;
        speed_select_i[3*c+:3] <= s;
        @(posedge clk_sys_i);
        cfg_we_i <= 2'h0;
        repeat (2) @(negedge clk_sys_i);
    endtask : wr
    // Skips the first tick: a write leaves the counter mid-count
    task automatic period(input int c, input logic b, input int e);
        int n;
        repeat (2)
        begin
            n = 0;
            do
            begin
                @(negedge clk_sys_i);
                n++;
            end
            while ((b ? bit_tick_o[c] : sample_tick_o[c]) !== 1'b1 && n < 9000);
        end
        cmp(16'(n), 16'(e));
    endtask : period
    task automatic close_out;
        if (miscompares == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // ==========
    // Tests
    initial
    begin
        repeat (40000) @(posedge clk_sys_i);
        miscompares++;
        close_out;
    end
    initial
    begin
        miscompares = 0;
        checks = 0;
        {cfg_we_i, prescale_select_i, sampling_ratio_select_i, speed_select_i, clear_to_send_n_i} = '0;
        rst_i = 1'b1;
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (2) @(negedge clk_sys_i);
        cmp(16'(prescale_select_o), 16'h0);
        cmp(16'(clear_to_send_n_o), 16'h0);
        @(posedge clk_sys_i);
        clear_to_send_n_i <= 2'h2;
        repeat (2) @(negedge clk_sys_i);
        cmp(16'(clear_to_send_n_o), 16'h2);
        for (int s = 0; s < 7; s++)
        begin
            wr(0, s[0], 1'b0, s[2:0]);
            cmp(16'({prescale_select_o[0], speed_select_o[2:0], ext_src_o[0]}), 16'({s[0], s[2:0], 1'b0}));
            period(0, 1'b0, (s[0] ? 30 : 10) << s);
        end
        wr(0, 1'b1, 1'b0, 3'h0);
        period(0, 1'b0, 30);
        wr(0, 1'b0, 1'b0, 3'h7);
        cmp(16'(ext_src_o), 16'h1);
        period(0, 1'b0, 64);
        period(0, 1'b1, 1024);
        wr(1, 1'b0, 1'b0, 3'h0);
        period(1, 1'b1, 160);
        wr(1, 1'b0, 1'b1, 3'h0);
        cmp(16'(sampling_ratio_select_o), 16'h2);
        period(1, 1'b1, 640);
        wr(1, 1'b1, 1'b1, 3'h1);
        period(1, 1'b1, 3840);
        close_out;
    end
endmodule : asbrg_top_tb_top
